// ---- rtl/ats_sequencer.sv ----
// Purpose : time-division sample sequencer with halt input and register bus
// Assumes : halt line and converter answers come from outside; halt and valid lines are resynchronised here, result data is not
// Notes   : zero-wait AHB-Lite slave, result queue takes one word per cycle with any valid pulse, lowest converter wins
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module ats_sequencer
   import ats_pkg::*;
#(
   parameter int QUEUE_DEPTH = 8
) (
   input  wire logic                                    clk_sys,
   input  wire logic                                    rst,
   input  wire logic [31:0]                             haddr,
   input  wire logic [1:0]                              htrans,
   input  wire logic                                    hwrite,
   input  wire logic [2:0]                              hsize,
   input  wire logic [31:0]                             hwdata,
   input  wire logic                                    hsel,
   input  wire logic                                    hready,
   output logic [31:0]                                  hrdata,
   output logic                                         hreadyout,
   output logic                                         hresp,
   input  wire logic                                    fabric_halt_trigger,
   output ats_pkg::ats_conv_req_type [ATS_NUM_CONV-1:0] conv_req,
   input  wire ats_pkg::ats_conv_rsp_type [ATS_NUM_CONV-1:0] conv_rsp,
   output logic                                         post_processing_complete_flag,
   output logic                                         irq
);
   import ats_pkg::*;

   // ==========================================================
   // input synchronisers
   // ==========================================================
   logic [2:0]              trig_sync_ff;
   logic                    trig_ff;
   logic [2:0]              vld_sync_ff [ATS_NUM_CONV];
   logic [ATS_NUM_CONV-1:0] vld_lvl_ff;
   logic [ATS_NUM_CONV-1:0] vld_pulse;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         trig_sync_ff <= 3'h0;
         trig_ff      <= 1'b0;
      end else begin
         trig_sync_ff <= {trig_sync_ff[1:0], fabric_halt_trigger};
         if (trig_sync_ff[2] == trig_sync_ff[1]) begin
            trig_ff <= trig_sync_ff[2];
         end
      end
   end

   generate
      for (genvar g = 0; g < ATS_NUM_CONV; g++) begin : g_vld
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               vld_sync_ff[g] <= 3'h0;
               vld_lvl_ff[g]  <= 1'b0;
            end else begin
               vld_sync_ff[g] <= {vld_sync_ff[g][1:0], conv_rsp[g].valid};
               if (vld_sync_ff[g][2] == vld_sync_ff[g][1]) begin
                  vld_lvl_ff[g] <= vld_sync_ff[g][2];
               end
            end
         end
         assign vld_pulse[g] = (vld_sync_ff[g][2] == vld_sync_ff[g][1])
                             & vld_sync_ff[g][2] & ~vld_lvl_ff[g];
      end
   endgenerate

   // ==========================================================
   // bus slave
   // ==========================================================
   logic                      ctrl_run_ff;
   logic [ATS_NUM_SLOTS-1:0]  slot_en_ff;
   logic [ATS_STATUS_W-1:0]   status_ff;
   logic [ATS_STATUS_W-1:0]   mask_ff;
   logic                      wr_pend_ff;
   logic [8:0]                wr_addr_ff;
   logic                      rd_pop;
   logic                      addr_ok;
   logic [15:0]               prog_mem [ATS_NUM_SLOTS*ATS_PROG_DEPTH];

   assign addr_ok   = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 9'h000;
      end else begin
         wr_pend_ff <= addr_ok & hwrite;
         wr_addr_ff <= haddr[8:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_run_ff <= 1'b0;
         mask_ff     <= '0;
      end else if (wr_pend_ff) begin
         if (wr_addr_ff == 9'(ATS_OFS_CTRL)) begin
            ctrl_run_ff <= hwdata[ATS_CTRL_RUN_BIT];
         end
         if (wr_addr_ff == 9'(ATS_OFS_MASK)) begin
            mask_ff <= hwdata[ATS_STATUS_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (wr_pend_ff && wr_addr_ff >= 9'(ATS_OFS_PROG)
          && wr_addr_ff[8:2] < 7'(ATS_OFS_PROG[7:2] + ATS_NUM_SLOTS*ATS_PROG_DEPTH)) begin
         prog_mem[6'(wr_addr_ff[8:2] - 7'(ATS_OFS_PROG[7:2]))] <= hwdata[15:0];
      end
   end

   // ==========================================================
   // timeslot rotation
   // ==========================================================
   logic                     slots_on;
   logic [1:0]               slot_ff;
   logic                     phase_ff;
   logic [3:0]               pc_ff   [ATS_NUM_SLOTS];
   logic [ATS_NUM_SLOTS-1:0] wait_ff;
   logic [1:0]               wconv_ff [ATS_NUM_SLOTS];
   ats_instr_type            cur;
   logic                     exec;

   assign slots_on = trig_ff | ctrl_run_ff;
   assign cur      = prog_mem[{slot_ff, pc_ff[slot_ff]}];
   assign exec     = slots_on & phase_ff & slot_en_ff[slot_ff] & ~wait_ff[slot_ff];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         slot_ff  <= 2'h0;
         phase_ff <= 1'b0;
      end else if (slots_on) begin
         phase_ff <= ~phase_ff;
         if (phase_ff) begin
            slot_ff <= slot_ff + 2'h1;
         end
      end
   end

   generate
      for (genvar s = 0; s < ATS_NUM_SLOTS; s++) begin : g_slot
         logic mine;
         logic wake;
         assign mine = exec & (slot_ff == 2'(s));
         assign wake = wait_ff[s] & vld_pulse[wconv_ff[s]];
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               pc_ff[s]    <= 4'h0;
               wait_ff[s]  <= 1'b0;
               wconv_ff[s] <= 2'h0;
               slot_en_ff[s] <= 1'b0;
            end else begin
               if (wake) begin
                  wait_ff[s] <= 1'b0;
                  pc_ff[s]   <= pc_ff[s] + 4'h1;
               end else if (mine) begin
                  unique case (cur.op)
                     ATS_OP_SAMPLE: begin
                        wait_ff[s]  <= 1'b1;
                        wconv_ff[s] <= cur.conv;
                     end
                     ATS_OP_STOP: ;
                     default: pc_ff[s] <= pc_ff[s] + 4'h1;
                  endcase
               end
               if (mine && cur.op == ATS_OP_STOP) begin
                  slot_en_ff[s] <= 1'b0;
               end else if (wr_pend_ff && wr_addr_ff == 9'(ATS_OFS_SLOT_EN)) begin
                  slot_en_ff[s] <= hwdata[s];
                  if (hwdata[s]) begin
                     pc_ff[s] <= hwdata[4*s+8 +: 4];
                  end
               end
            end
         end
      end
   endgenerate

   // ==========================================================
   // converter starts, results, flags
   // ==========================================================
   logic [11:0] queue_mem [QUEUE_DEPTH];
   logic [$clog2(QUEUE_DEPTH):0] q_wr_ff;
   logic [$clog2(QUEUE_DEPTH):0] q_rd_ff;
   logic        q_empty;
   logic [ATS_NUM_CONV-1:0] done_ev;

   assign q_empty = (q_wr_ff == q_rd_ff);
   assign rd_pop  = addr_ok & ~hwrite & (haddr[8:0] == 9'(ATS_OFS_RESULT)) & ~q_empty;

   generate
      for (genvar c = 0; c < ATS_NUM_CONV; c++) begin : g_conv
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               conv_req[c] <= '0;
            end else begin
               conv_req[c].start <= exec & (cur.op == ATS_OP_SAMPLE)
                                  & (cur.conv == 2'(c));
               if (exec && cur.op == ATS_OP_SAMPLE && cur.conv == 2'(c)) begin
                  conv_req[c].chan <= cur.chan;
               end
            end
         end
         assign done_ev[c] = vld_pulse[c];
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q_wr_ff <= '0;
         q_rd_ff <= '0;
      end else begin
         if (|vld_pulse) begin
            q_wr_ff <= q_wr_ff + 1'b1;
         end
         if (rd_pop) begin
            q_rd_ff <= q_rd_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      for (int c = ATS_NUM_CONV - 1; c >= 0; c--) begin
         if (vld_pulse[c]) begin
            queue_mem[q_wr_ff[$clog2(QUEUE_DEPTH)-1:0]] <= conv_rsp[c].data;
         end
      end
   end

   logic flag_ev;
   assign flag_ev = exec & (cur.op == ATS_OP_FLAG);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         post_processing_complete_flag <= 1'b0;
      end else begin
         post_processing_complete_flag <= flag_ev;
      end
   end

   logic [ATS_STATUS_W-1:0] set_v;
   logic [ATS_STATUS_W-1:0] clr_v;
   assign set_v = {flag_ev, 1'b0, done_ev};
   assign clr_v = (wr_pend_ff && wr_addr_ff == 9'(ATS_OFS_STATUS))
                ? hwdata[ATS_STATUS_W-1:0] : '0;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         status_ff <= '0;
         irq       <= 1'b0;
      end else begin
         status_ff <= (status_ff & ~clr_v) | set_v;
         irq       <= |(((status_ff & ~clr_v) | set_v) & mask_ff);
      end
   end

   // ==========================================================
   // read data
   // ==========================================================
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_ok && !hwrite) begin
         unique case (haddr[8:0])
            9'(ATS_OFS_CTRL):    hrdata <= {31'h0, ctrl_run_ff};
            9'(ATS_OFS_SLOT_EN): hrdata <= {28'h0, slot_en_ff};
            9'(ATS_OFS_STATUS):  hrdata <= {27'h0, status_ff};
            9'(ATS_OFS_MASK):    hrdata <= {27'h0, mask_ff};
            9'(ATS_OFS_RESULT):  hrdata <= {q_empty, 19'h0,
                                            queue_mem[q_rd_ff[$clog2(QUEUE_DEPTH)-1:0]]};
            9'(ATS_OFS_STATE):   hrdata <= {22'h0, wait_ff, trig_ff, slots_on,
                                            slot_ff, 1'b0, phase_ff};
            default:             hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   AST_ROTATE: assert property (@(posedge clk_sys) disable iff (rst)
      slots_on && phase_ff |=> slot_ff == $past(slot_ff) + 2'h1)
      else $error("slot did not rotate");
   AST_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      !slots_on |=> $stable(slot_ff))
      else $error("slot moved while halted");
   AST_START: assert property (@(posedge clk_sys) disable iff (rst)
      exec && cur.op == ATS_OP_SAMPLE |=> conv_req[$past(cur.conv)].start)
      else $error("start strobe missing");
   AST_WAKE: assert property (@(posedge clk_sys) disable iff (rst)
      wait_ff[0] && vld_pulse[wconv_ff[0]] |=> !wait_ff[0])
      else $error("waiting slot not released");
   AST_QUEUE: assert property (@(posedge clk_sys) disable iff (rst)
      |vld_pulse |=> q_wr_ff == $past(q_wr_ff) + 1'b1)
      else $error("result not queued");
   AST_STOP: assert property (@(posedge clk_sys) disable iff (rst)
      exec && cur.op == ATS_OP_STOP |=> !slot_en_ff[$past(slot_ff)])
      else $error("stop did not clear enable");
   AST_IRQ: assert property (@(posedge clk_sys) disable iff (rst)
      done_ev[1] && mask_ff[1] |=> irq && status_ff[1])
      else $error("completion interrupt missing");
   AST_FLAG: assert property (@(posedge clk_sys) disable iff (rst)
      flag_ev |=> post_processing_complete_flag && status_ff[ATS_ST_PPC_BIT])
      else $error("completion flag missing");
   AST_READY: assert property (@(posedge clk_sys) disable iff (rst)
      hreadyout && !hresp)
      else $error("bus not zero wait");
   AST_EN: assert property (@(posedge clk_sys) disable iff (rst)
      !slots_on |=> !conv_req[0].start && !conv_req[1].start && !conv_req[2].start)
      else $error("converter started while halted");
   COV_SAMPLE: cover property (@(posedge clk_sys) disable iff (rst)
      exec && cur.op == ATS_OP_SAMPLE ##[1:200] |vld_pulse);
   COV_SHARED: cover property (@(posedge clk_sys) disable iff (rst)
      wait_ff[0] && wait_ff[1] && wconv_ff[0] == wconv_ff[1]);
   COV_IRQ: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
   COV_HALT: cover property (@(posedge clk_sys) disable iff (rst) $fell(slots_on));
endmodule

// ---- rtl/ats_pkg.sv ----
// Purpose : shared constants and types for the timeslot sequencer
// Assumes : one clock, register words on AHB-Lite
// Notes   : offsets are byte addresses
package ats_pkg;
   localparam int          ATS_NUM_SLOTS    = 4;
   localparam int          ATS_NUM_CONV     = 3;
   localparam int          ATS_PROG_DEPTH   = 16;
   localparam int          ATS_SLOT_CYCLES  = 2;
   localparam logic [7:0]  ATS_OFS_CTRL     = 8'h00;
   localparam logic [7:0]  ATS_OFS_SLOT_EN  = 8'h04;
   localparam logic [7:0]  ATS_OFS_STATUS   = 8'h08;
   localparam logic [7:0]  ATS_OFS_MASK     = 8'h0C;
   localparam logic [7:0]  ATS_OFS_RESULT   = 8'h10;
   localparam logic [7:0]  ATS_OFS_STATE    = 8'h14;
   localparam logic [7:0]  ATS_OFS_PROG     = 8'h40;
   localparam int          ATS_CTRL_RUN_BIT = 0;
   localparam int          ATS_ST_DONE_LSB  = 0;
   localparam int          ATS_ST_PPC_BIT   = 4;
   localparam int          ATS_STATUS_W     = 5;
   // instruction: [15:14] op, [13:12] converter, [11:8] channel, [7:0] data
   localparam logic [1:0]  ATS_OP_NOP       = 2'h0;
   localparam logic [1:0]  ATS_OP_SAMPLE    = 2'h1;
   localparam logic [1:0]  ATS_OP_STOP      = 2'h2;
   localparam logic [1:0]  ATS_OP_FLAG      = 2'h3;
   typedef struct packed {
      logic [1:0] op;
      logic [1:0] conv;
      logic [3:0] chan;
      logic [7:0] data;
   } ats_instr_type;
   typedef struct packed {
      logic       start;
      logic [3:0] chan;
   } ats_conv_req_type;
   typedef struct packed {
      logic        valid;
      logic [11:0] data;
   } ats_conv_rsp_type;
endpackage

// ---- test/ats_conv_model.sv ----
// Purpose : converter model answering start strobes with one valid pulse each
// Assumes : a start that arrives while a conversion runs is dropped
// Notes   : data line shows the inverse of the last result while valid is low
`timescale 1ns/100ps
module ats_conv_model (
   input  wire logic                                                clk_sys,
   input  wire logic                                                rst,
   input  wire ats_pkg::ats_conv_req_type [ats_pkg::ATS_NUM_CONV-1:0] conv_req,
   input  wire logic [7:0]                                          latency,
   output ats_pkg::ats_conv_rsp_type [ats_pkg::ATS_NUM_CONV-1:0]     conv_rsp
);
   import ats_pkg::*;
   // ==========================================================
   // conversion state per converter
   logic [7:0] cnt_ff  [ATS_NUM_CONV];
   logic [3:0] chan_ff [ATS_NUM_CONV];
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < ATS_NUM_CONV; i++) begin
            cnt_ff[i] <= 8'h00;
            chan_ff[i] <= 4'h0;
            conv_rsp[i] <= '0;
         end
      end else begin
         for (int i = 0; i < ATS_NUM_CONV; i++) begin
            if (cnt_ff[i] != 8'h00) begin
               cnt_ff[i] <= cnt_ff[i] - 8'h01;
               if (cnt_ff[i] == 8'h08) begin
                  conv_rsp[i].valid <= 1'b1;
                  conv_rsp[i].data <= {chan_ff[i], 8'h50 + 8'(i)};
               end
               if (cnt_ff[i] == 8'h01) begin
                  conv_rsp[i].valid <= 1'b0;
                  conv_rsp[i].data <= ~conv_rsp[i].data;
               end
            end else if (conv_req[i].start) begin
               cnt_ff[i] <= latency + 8'h08;
               chan_ff[i] <= conv_req[i].chan;
            end
         end
      end
   end
endmodule

// ---- test/tb.sv ----
// Purpose : self-checking bench for the timeslot sequencer
// Assumes : bench acts as host and fabric, model acts as converters
// Notes   : zero-wait bus, waits are still bounded
`timescale 1ns/100ps
module tb;
   import ats_pkg::*;
   // ==========================================================
   // signals
   logic                                   clk_sys = 1'b0;
   logic                                   rst = 1'b1;
   logic                                   hwrite = 1'b0;
   logic                                   fabric_halt_trigger = 1'b0;
   logic [31:0]                            haddr = 32'h0;
   logic [31:0]                            hwdata = 32'h0;
   logic [31:0]                            hrdata;
   logic [31:0]                            rd;
   logic [1:0]                             htrans = 2'h0;
   logic                                   hreadyout;
   logic                                   hresp;
   logic                                   ppc;
   logic                                   irq;
   logic [7:0]                             lat = 8'h14;
   ats_conv_req_type [ATS_NUM_CONV-1:0]    conv_req;
   ats_conv_rsp_type [ATS_NUM_CONV-1:0]    conv_rsp;
   int                                     mismatches = 0;
   int                                     n_compared = 0;
   int                                     cyc = 0;
   int                                     nflag = 0;
   int                                     n0 = 0;
   int                                     n2 = 0;
   int                                     t0 = 0;
   int                                     t1 = 0;
   always #2 clk_sys = ~clk_sys;
   ats_sequencer #(.QUEUE_DEPTH(8)) u_ats_sequencer (
      .clk_sys(clk_sys), .rst(rst), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hsel(1'b1), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .fabric_halt_trigger(fabric_halt_trigger),
      .conv_req(conv_req), .conv_rsp(conv_rsp), .post_processing_complete_flag(ppc),
      .irq(irq));
   ats_conv_model u_ats_conv_model (
      .clk_sys(clk_sys), .rst(rst), .conv_req(conv_req), .latency(lat),
      .conv_rsp(conv_rsp));
   // ==========================================================
   // monitor of starts and completion pulses
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (conv_req[0].start === 1'b1) begin
         n0 <= n0 + 1;
         if (n0 == 0) t0 <= cyc;
         t1 <= cyc;
      end
      if (conv_req[2].start === 1'b1) n2 <= n2 + 1;
      if (ppc === 1'b1) nflag <= nflag + 1;
   end
   // ==========================================================
   // bus and check tasks
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do begin @(posedge clk_sys); k++; end while (hreadyout !== 1'b1 && k < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge clk_sys); k++; end while (hreadyout !== 1'b1 && k < 50);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic wait_irq(input logic v);
      int k;
      k = 0;
      while (irq !== v && k < 20) begin @(posedge clk_sys); k++; end
      chk({31'h0, irq}, {31'h0, v});
   endtask
   function automatic logic [31:0] ins(logic [1:0] op, logic [1:0] cv, logic [3:0] ch);
      return {16'h0, op, cv, ch, 8'h00};
   endfunction
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset;
      rdchk(ATS_OFS_CTRL, 32'h0);
      rdchk(ATS_OFS_STATUS, 32'h0);
      rdchk(ATS_OFS_MASK, 32'h0);
      rdchk(8'h20, 32'h0);
      rdchk(ATS_OFS_RESULT, 32'h8000_0000);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic t_halt;
      int k;
      xfer(1'b1, ATS_OFS_PROG, ins(ATS_OP_SAMPLE, 2'h2, 4'h3));
      xfer(1'b1, ATS_OFS_PROG + 8'h04, ins(ATS_OP_NOP, 2'h0, 4'h0));
      xfer(1'b1, ATS_OFS_PROG + 8'h08, ins(ATS_OP_STOP, 2'h0, 4'h0));
      xfer(1'b1, ATS_OFS_SLOT_EN, 32'h1);
      repeat (40) @(posedge clk_sys);
      chk(32'(n2), 32'h0);
      fabric_halt_trigger <= 1'b1;
      k = 0;
      do begin xfer(1'b0, ATS_OFS_STATUS, 32'h0); k++; end while (rd[2] !== 1'b1 && k < 100);
      chk(rd & 32'h1F, 32'h04);
      chk(32'(n2), 32'h1);
      xfer(1'b0, ATS_OFS_STATE, 32'h0);
      chk(rd & 32'h3F0, 32'h030);
      rdchk(ATS_OFS_RESULT, 32'h352);
      rdchk(ATS_OFS_RESULT, 32'h8000_0000);
      repeat (2 * ATS_NUM_SLOTS * ATS_SLOT_CYCLES) @(posedge clk_sys);
      xfer(1'b0, ATS_OFS_SLOT_EN, 32'h0);
      chk({31'h0, rd[0]}, 32'h0);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b1, ATS_OFS_MASK, 32'h4);
      wait_irq(1'b1);
      xfer(1'b1, ATS_OFS_STATUS, 32'h4);
      wait_irq(1'b0);
   endtask
   task automatic t_share;
      int k;
      int d;
      fabric_halt_trigger <= 1'b0;
      lat <= 8'h3C;
      xfer(1'b1, ATS_OFS_PROG, ins(ATS_OP_SAMPLE, 2'h0, 4'h1));
      xfer(1'b1, ATS_OFS_PROG + 8'h04, ins(ATS_OP_FLAG, 2'h0, 4'h0));
      xfer(1'b1, ATS_OFS_PROG + 8'h08, ins(ATS_OP_STOP, 2'h0, 4'h0));
      xfer(1'b1, 8'h80, ins(ATS_OP_SAMPLE, 2'h0, 4'h2));
      xfer(1'b1, 8'h84, ins(ATS_OP_FLAG, 2'h0, 4'h0));
      xfer(1'b1, 8'h88, ins(ATS_OP_STOP, 2'h0, 4'h0));
      xfer(1'b1, ATS_OFS_CTRL, 32'h1);
      xfer(1'b1, ATS_OFS_SLOT_EN, 32'h3);
      k = 0;
      while (nflag < 2 && k < 2000) begin @(posedge clk_sys); k++; end
      chk(32'(n0), 32'h2);
      chk(32'(nflag), 32'h2);
      xfer(1'b0, ATS_OFS_RESULT, 32'h0);
      chk({24'h0, rd[7:0]}, 32'h50);
      d = (rd[11:8] == 4'h1) ? ATS_SLOT_CYCLES : (ATS_NUM_SLOTS - 1) * ATS_SLOT_CYCLES;
      chk(32'(t1 - t0), 32'(d));
      rdchk(ATS_OFS_RESULT, 32'h8000_0000);
      xfer(1'b0, ATS_OFS_STATUS, 32'h0);
      chk(rd & 32'h11, 32'h11);
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_halt();
      t_share();
      results();
   end
   initial begin
      #80000;
      mismatches++;
      results();
   end
endmodule
